// ---- rtl/cbric_top.sv ----
// Notes on behaviour
// - drive data only while drive enable high
// - drive enable low keeps drivers off always
// - read cycles never drive the data bus
// - ready low in phase one halts, address held
// - halt lasts until ready sampled high
// - write cycles ignore ready; stall deferred
// - interrupt waits for instruction completion
// - mask flag set means request ignored
// - push program counter, then status
// - set mask flag after the pushes
// - fetch vector from FFFE then FFFF
// - no recognition while ready is low
// - eight-bit bidirectional data bus
// - sample request in phase two
module cbric_top #(
	parameter int ADDR_PINS = 16
) (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	// processor bus pins
	input wire logic PHI1_I,
	input wire logic PHI2_I,
	input wire logic RDY_I,
	input wire logic IRQ_N_I,
	input wire logic DATA_OUT_DRIVE_ENABLE_I,
	input wire logic [7:0] DATA_I,
	output logic [7:0] DATA_O,
	output logic DATA_OE_O,
	output logic [ADDR_PINS-1:0] ADDR_O,
	output logic RW_O,
	// processor core side
	input wire logic [15:0] CORE_ADDR_I,
	input wire logic CORE_WRITE_I,
	input wire logic [7:0] CORE_WDATA_I,
	input wire logic CORE_INSN_DONE_I,
	input wire logic [15:0] CORE_PC_I,
	input wire logic [7:0] CORE_STATUS_I,
	input wire logic [7:0] CORE_SP_I,
	output logic CORE_STEP_O,
	output logic [7:0] CORE_RDATA_O,
	output logic CORE_HOLD_O,
	output logic CORE_MASK_SET_O,
	output logic CORE_PC_LOAD_O,
	output logic [15:0] CORE_PC_O,
	output logic [7:0] CORE_SP_O
);

	localparam int SW = 13;

	logic [SW-1:0] pins_s;
	logic phi1_s, phi2_s, rdy_s, irq_n_s, dbe_s;
	logic [7:0] data_s;
	logic phi1_d_reg, phi2_d_reg;
	logic phi1_rise, phi2_fall, step, take;
	logic halt_reg, wr_reg, irq_pend_reg;
	logic [15:0] addr_reg, pc_save_reg;
	logic [7:0] wdata_reg, status_reg, sp_reg, vec_lo_reg;
	cbric_pkg::cbric_state_t state_reg;

	// every pin level is synchronised before use
	cbric_sync #(
		.W(SW)
	) u_sync (
		.clk_i(MCLK_I),
		.rst_n_i(RSTN_I),
		.async_i({PHI1_I, PHI2_I, RDY_I, IRQ_N_I, DATA_OUT_DRIVE_ENABLE_I, DATA_I}),
		.sync_o(pins_s)
	);

	assign {phi1_s, phi2_s, rdy_s, irq_n_s, dbe_s, data_s} = pins_s;

	// phase edges seen on the synchronised clocks
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			phi1_d_reg <= 1'b0;
			phi2_d_reg <= 1'b0;
		end else begin
			phi1_d_reg <= phi1_s;
			phi2_d_reg <= phi2_s;
		end
	end

	assign phi1_rise = phi1_s & ~phi1_d_reg;
	assign phi2_fall = ~phi2_s & phi2_d_reg;
	// a cycle completes at phase two end unless halted with ready still low
	assign step = phi2_fall & (~halt_reg | rdy_s);
	// recognition at the end of the last cycle of an instruction
	assign take = step & (state_reg == cbric_pkg::CBRIC_S_IDLE) & CORE_INSN_DONE_I
		& irq_pend_reg & ~CORE_STATUS_I[cbric_pkg::MASK_BIT]
		& rdy_s;

	// ready handling: only read cycles halt, held until ready is high at phase two;
	// the setup edge is skipped because wr_reg still shows the previous cycle there
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			halt_reg <= 1'b0;
		end else if (halt_reg) begin
			if (phi2_fall && rdy_s) begin
				halt_reg <= 1'b0;
			end
		end else if (phi1_s && !phi1_rise && !rdy_s && !wr_reg) begin
			halt_reg <= 1'b1;
		end
	end

	// request level sampled while phase two is high
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			irq_pend_reg <= 1'b0;
		end else if (phi2_s) begin
			irq_pend_reg <= ~irq_n_s;
		end
	end

	// entry sequence: three pushes then two vector reads
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_reg <= cbric_pkg::CBRIC_S_IDLE;
		end else if (step) begin
			case (state_reg)
				cbric_pkg::CBRIC_S_IDLE: begin
					if (take) begin
						state_reg <= cbric_pkg::CBRIC_S_PCH;
					end
				end
				cbric_pkg::CBRIC_S_PCH: state_reg <= cbric_pkg::CBRIC_S_PCL;
				cbric_pkg::CBRIC_S_PCL: state_reg <= cbric_pkg::CBRIC_S_PSR;
				cbric_pkg::CBRIC_S_PSR: state_reg <= cbric_pkg::CBRIC_S_VLO;
				cbric_pkg::CBRIC_S_VLO: state_reg <= cbric_pkg::CBRIC_S_VHI;
				cbric_pkg::CBRIC_S_VHI: state_reg <= cbric_pkg::CBRIC_S_IDLE;
				default: state_reg <= cbric_pkg::CBRIC_S_IDLE;
			endcase
		end
	end

	// state saved at recognition, stack pointer walks down per push
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pc_save_reg <= cbric_pkg::ADDR_RST;
			status_reg <= cbric_pkg::BYTE_RST;
			sp_reg <= cbric_pkg::BYTE_RST;
			vec_lo_reg <= cbric_pkg::BYTE_RST;
		end else if (take) begin
			pc_save_reg <= CORE_PC_I;
			status_reg <= CORE_STATUS_I;
			sp_reg <= CORE_SP_I;
		end else if (step) begin
			if (state_reg == cbric_pkg::CBRIC_S_PCH || state_reg == cbric_pkg::CBRIC_S_PCL
				|| state_reg == cbric_pkg::CBRIC_S_PSR) begin
				sp_reg <= sp_reg - 8'h01;
			end
			if (state_reg == cbric_pkg::CBRIC_S_VLO) begin
				vec_lo_reg <= data_s;
			end
		end
	end

	// bus cycle set up at phase one start; a halted cycle keeps its address
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			addr_reg <= cbric_pkg::ADDR_RST;
			wr_reg <= 1'b0;
			wdata_reg <= cbric_pkg::BYTE_RST;
		end else if (phi1_rise && !halt_reg) begin
			case (state_reg)
				cbric_pkg::CBRIC_S_PCH: begin
					addr_reg <= {cbric_pkg::STACK_PAGE, sp_reg};
					wr_reg <= 1'b1;
					wdata_reg <= pc_save_reg[15:8];
				end
				cbric_pkg::CBRIC_S_PCL: begin
					addr_reg <= {cbric_pkg::STACK_PAGE, sp_reg};
					wr_reg <= 1'b1;
					wdata_reg <= pc_save_reg[7:0];
				end
				cbric_pkg::CBRIC_S_PSR: begin
					addr_reg <= {cbric_pkg::STACK_PAGE, sp_reg};
					wr_reg <= 1'b1;
					wdata_reg <= status_reg;
				end
				cbric_pkg::CBRIC_S_VLO: begin
					addr_reg <= cbric_pkg::VEC_LO_ADDR;
					wr_reg <= 1'b0;
				end
				cbric_pkg::CBRIC_S_VHI: begin
					addr_reg <= cbric_pkg::VEC_HI_ADDR;
					wr_reg <= 1'b0;
				end
				default: begin
					addr_reg <= CORE_ADDR_I;
					wr_reg <= CORE_WRITE_I;
					wdata_reg <= CORE_WDATA_I;
				end
			endcase
		end
	end

	// pin outputs: drivers on only for writes with drive enable high
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			DATA_OE_O <= 1'b0;
			DATA_O <= cbric_pkg::BYTE_RST;
			ADDR_O <= '0;
			RW_O <= 1'b1;
		end else begin
			DATA_OE_O <= dbe_s & wr_reg;
			DATA_O <= wdata_reg;
			ADDR_O <= addr_reg[ADDR_PINS-1:0];
			RW_O <= ~wr_reg;
		end
	end

	// core side handshake
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			CORE_STEP_O <= 1'b0;
			CORE_RDATA_O <= cbric_pkg::BYTE_RST;
			CORE_HOLD_O <= 1'b0;
			CORE_MASK_SET_O <= 1'b0;
			CORE_PC_LOAD_O <= 1'b0;
			CORE_PC_O <= cbric_pkg::ADDR_RST;
			CORE_SP_O <= cbric_pkg::BYTE_RST;
		end else begin
			CORE_STEP_O <= step & (state_reg == cbric_pkg::CBRIC_S_IDLE);
			CORE_HOLD_O <= (state_reg != cbric_pkg::CBRIC_S_IDLE) | take;
			CORE_MASK_SET_O <= step & (state_reg == cbric_pkg::CBRIC_S_PSR);
			CORE_PC_LOAD_O <= step & (state_reg == cbric_pkg::CBRIC_S_VHI);
			if (step && !wr_reg) begin
				CORE_RDATA_O <= data_s;
			end
			if (step && state_reg == cbric_pkg::CBRIC_S_VHI) begin
				CORE_PC_O <= {data_s, vec_lo_reg};
				CORE_SP_O <= sp_reg;
			end
		end
	end

	// named sequences for the entry steps
	sequence s_take;
		take;
	endsequence

	sequence s_push_status;
		step && state_reg == cbric_pkg::CBRIC_S_PSR;
	endsequence

	property p_oe_needs_enable;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		DATA_OE_O |-> $past(dbe_s);
	endproperty
	a_oe_needs_enable: assert property (p_oe_needs_enable)
		else $error("data driven without drive enable");

	property p_enable_low_off;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		!dbe_s |=> !DATA_OE_O;
	endproperty
	a_enable_low_off: assert property (p_enable_low_off)
		else $error("drivers on while drive enable low");

	property p_read_no_drive;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		!wr_reg |=> !DATA_OE_O && RW_O;
	endproperty
	a_read_no_drive: assert property (p_read_no_drive)
		else $error("drivers on during read cycle");

	property p_halt_on_ready_low;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		phi1_s && !phi1_rise && !rdy_s && !wr_reg |=> halt_reg;
	endproperty
	a_halt_on_ready_low: assert property (p_halt_on_ready_low)
		else $error("read cycle did not halt on ready low");

	property p_addr_held;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		halt_reg && $past(halt_reg) |=> $stable(addr_reg);
	endproperty
	a_addr_held: assert property (p_addr_held)
		else $error("address moved while halted");

	property p_halt_persists;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		halt_reg && !rdy_s |-> !step ##1 halt_reg;
	endproperty
	a_halt_persists: assert property (p_halt_persists)
		else $error("halt ended with ready low");

	property p_write_not_halted;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		wr_reg && !halt_reg |=> !halt_reg;
	endproperty
	a_write_not_halted: assert property (p_write_not_halted)
		else $error("write cycle stalled");

	property p_masked_ignored;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		CORE_STATUS_I[cbric_pkg::MASK_BIT] || !rdy_s || !CORE_INSN_DONE_I |-> !take;
	endproperty
	a_masked_ignored: assert property (p_masked_ignored)
		else $error("request taken when not allowed");

	property p_take_starts_push;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		s_take |=> state_reg == cbric_pkg::CBRIC_S_PCH ##1 CORE_HOLD_O;
	endproperty
	a_take_starts_push: assert property (p_take_starts_push)
		else $error("entry sequence did not start");

	property p_mask_after_push;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		s_push_status |=> CORE_MASK_SET_O && state_reg == cbric_pkg::CBRIC_S_VLO;
	endproperty
	a_mask_after_push: assert property (p_mask_after_push)
		else $error("mask not set after status push");

	property p_vector_addr;
		@(posedge MCLK_I) disable iff (!RSTN_I)
		phi1_rise && !halt_reg && state_reg == cbric_pkg::CBRIC_S_VLO
			|=> addr_reg == 16'hFFFE ##0 !wr_reg;
	endproperty
	a_vector_addr: assert property (p_vector_addr)
		else $error("vector low fetch not at FFFE");

endmodule

// ---- shared/cbric_pkg.sv ----
package cbric_pkg;

	// widths of the processor buses
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;

	// interrupt vector, low byte then high byte
	localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
	localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;

	// page that holds the stack
	localparam logic [7:0] STACK_PAGE = 8'h01;

	// position of the interrupt mask flag in the status byte
	localparam int MASK_BIT = 2;

	// reset values
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// interrupt entry sequence, one bus cycle per state
	typedef enum logic [5:0] {
		CBRIC_S_IDLE = 6'b00_0001,
		CBRIC_S_PCH = 6'b00_0010,
		CBRIC_S_PCL = 6'b00_0100,
		CBRIC_S_PSR = 6'b00_1000,
		CBRIC_S_VLO = 6'b01_0000,
		CBRIC_S_VHI = 6'b10_0000
	} cbric_state_t;

endpackage

// ---- rtl/cbric_sync.sv ----
// two-flop synchroniser for a group of pin levels
module cbric_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= '0;
			sync_o <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end

endmodule

// ---- testbench/cbric_mem_model.sv ----
// memory and peripherals on the far side of the processor bus
module cbric_mem_model (
	// clock
	input wire logic clk_i,
	// bus from the processor
	input wire logic [15:0] addr_i,
	input wire logic rw_i,
	// read data back to the processor
	output logic [7:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last = 8'h00;
	// reads return a byte made from the address; a released bus shows no stale byte
	always @(posedge clk_i) begin
		if (rw_i) begin
			last <= addr_i[7:0] ^ addr_i[15:8] ^ 8'h5a;
			data_o <= #1 addr_i[7:0] ^ addr_i[15:8] ^ 8'h5a;
		end else begin
			data_o <= #1 ~last;
		end
	end
endmodule

// ---- testbench/test_cpu_bus_ready_irq_control.sv ----
// processor bus control and interrupt entry bench
module test_cpu_bus_ready_irq_control;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [15:0] a; logic rw; logic oe; logic [7:0] d;} cbric_note_t;
	logic clk = 0, rstn = 0, phi1 = 0, phi2 = 0, rdy = 1, irqn = 1, dbe = 0, dbe_en = 1;
	logic [15:0] caddr = 0, cpc = 0, a = 0, addr, pco;
	logic cwr = 0, cdone = 0, rw, oe, stp, hold, mset, pload;
	logic [7:0] cwd = 0, cst = 0, csp = 0, d = 0, din, dout, rdata, spo;
	logic [8:0] sn;
	cbric_note_t n;
	cbric_note_t bq[$];
	logic [8:0] sq[$];
	logic [23:0] pq[$];
	int err_total = 0, checked = 0, seed = 32'h7f80, nmask = 0, nload = 0;
	// clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	cbric_top dut (.MCLK_I(clk), .RSTN_I(rstn), .PHI1_I(phi1), .PHI2_I(phi2), .RDY_I(rdy),
		.IRQ_N_I(irqn), .DATA_OUT_DRIVE_ENABLE_I(dbe), .DATA_I(din), .DATA_O(dout),
		.DATA_OE_O(oe), .ADDR_O(addr), .RW_O(rw), .CORE_ADDR_I(caddr), .CORE_WRITE_I(cwr),
		.CORE_WDATA_I(cwd), .CORE_INSN_DONE_I(cdone), .CORE_PC_I(cpc), .CORE_STATUS_I(cst),
		.CORE_SP_I(csp), .CORE_STEP_O(stp), .CORE_RDATA_O(rdata), .CORE_HOLD_O(hold),
		.CORE_MASK_SET_O(mset), .CORE_PC_LOAD_O(pload), .CORE_PC_O(pco), .CORE_SP_O(spo));
	cbric_mem_model mem (.clk_i(clk), .addr_i(addr), .rw_i(rw), .data_o(din));
	function automatic logic [7:0] mbyte(input logic [15:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h5a;
	endfunction
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) begin
			@(posedge clk);
			#1;
		end
	endtask
	// one bus cycle on the phase pins; nb notes the bus result, ns the core step
	task cyc(input logic [15:0] x, input logic w, input logic [7:0] y, input logic nb, ns);
		caddr = x;
		cwr = w;
		cwd = y;
		if (nb) bq.push_back({x, ~w, w & dbe_en, w ? y : 8'h00});
		if (ns) sq.push_back({~w, mbyte(x)});
		phi1 = 1;
		tick(6);
		phi1 = 0;
		tick(2);
		phi2 = 1;
		dbe = dbe_en;
		tick(6);
		phi2 = 0;
		dbe = 0;
		tick(4);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// bus watcher: address always, the rest once the cycle completes
	always @(negedge phi2) begin
		if (bq.size() > 0) begin
			n = bq[0];
			chk({8'h00, addr}, {8'h00, n.a});
			if (rdy || !n.rw) begin
				void'(bq.pop_front());
				chk({rw, oe, n.rw ? 8'h00 : dout}, {n.rw, n.oe, n.d});
			end
		end
	end
	// core side watcher
	always @(posedge clk) begin
		if (stp === 1'b1 && sq.size() > 0) begin
			sn = sq.pop_front();
			repeat (2) @(posedge clk);
			if (sn[8]) chk({16'h0000, rdata}, {16'h0000, sn[7:0]});
		end
	end
	// entry pulses
	always @(posedge clk) begin
		if (mset === 1'b1) nmask++;
		if (pload === 1'b1) begin
			nload++;
			chk({spo, pco}, pq.size() > 0 ? pq.pop_front() : 24'h0000_00);
		end
	end
	initial begin
		#100000;
		err_total++;
		$display("[FAIL] %0t run did not finish", $time);
		print_verdict;
	end
	initial begin
		tick(16);
		rstn = 1;
		tick(4);
		// random reads and writes, then a write with the drive enable held low
		repeat (8) begin
			a = $random(seed);
			d = $random(seed);
			cyc(a, a[0], d, 1, 1);
		end
		dbe_en = 0;
		cyc(a ^ 16'h0f0f, 1, ~d, 1, 1);
		dbe_en = 1;
		$display("test bus cycles done");
		// ready low: write completes, next read halts until ready returns
		rdy = 0;
		cyc(a + 16'h0001, 1, d, 1, 1);
		cyc(a + 16'h0002, 0, 8'h00, 1, 1);
		cyc(a + 16'h0002, 0, 8'h00, 0, 0);
		rdy = 1;
		cyc(a + 16'h0002, 0, 8'h00, 0, 0);
		$display("test ready done");
		// interrupt held low; taken only at instruction end with mask clear
		cst = $random(seed);
		cst[cbric_pkg::MASK_BIT] = 1'b0;
		cpc = $random(seed);
		csp = $random(seed);
		irqn = 0;
		repeat (2) cyc(a - 16'h0010, 0, 8'h00, 1, 1);
		cdone = 1;
		cyc(a - 16'h0020, 0, 8'h00, 1, 1);
		pq.push_back({csp - 8'd3, mbyte(16'hffff), mbyte(16'hfffe)});
		cyc({cbric_pkg::STACK_PAGE, csp}, 1, cpc[15:8], 1, 0);
		chk({16'h0000, 7'h00, hold}, 24'h0000_01);
		cdone = 0;
		cyc({cbric_pkg::STACK_PAGE, csp - 8'd1}, 1, cpc[7:0], 1, 0);
		cyc({cbric_pkg::STACK_PAGE, csp - 8'd2}, 1, cst, 1, 0);
		cyc(cbric_pkg::VEC_LO_ADDR, 0, 8'h00, 1, 0);
		cyc(cbric_pkg::VEC_HI_ADDR, 0, 8'h00, 1, 0);
		tick(6);
		chk({16'h0000, nmask[3:0], nload[3:0]}, 24'h0000_11);
		// mask set: the request is ignored
		cst[cbric_pkg::MASK_BIT] = 1'b1;
		cdone = 1;
		repeat (2) cyc(a - 16'h0030, 0, 8'h00, 1, 1);
		cdone = 0;
		irqn = 1;
		$display("test interrupt done");
		tick(4);
		for (int i = 0; i < 40 && (bq.size() + sq.size()) > 0; i++) tick(1);
		chk({16'h0000, nmask[3:0], nload[3:0]}, 24'h0000_11);
		if ((bq.size() + sq.size()) > 0) begin
			err_total++;
			$display("[FAIL] %0t cycles left unfinished", $time);
		end
		print_verdict;
	end
endmodule
